// ### src/sga_pkg.sv
package sga_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_BANKS = 4;
    localparam int BANK_BYTES = 64;
    localparam int BANK_BITS = 512;
    localparam int MEM_BYTES = NUM_BANKS * BANK_BYTES;
    localparam logic [1:0] BANK_USER = 2'h3;
    // lock and identity bit positions
    localparam logic [7:0] BYTE_READ_LOCK = 8'hE5;
    localparam int BIT_READ_LOCK = 0;
    localparam logic [7:0] BYTE_WRITE_LOCK = 8'hE9;
    localparam int BIT_WLOCK_LOW = 7;
    localparam int BIT_WLOCK_ALL = 6;
    localparam int CODE_LSB = 0;
    localparam int CODE_W = 4;
    // oscillator power and soft reset byte
    localparam logic [7:0] BYTE_OSC_SRST = 8'hCF;
    localparam int BIT_SOFT_RST = 6;
    localparam logic [7:0] OSC_SRST_WR_MASK = 8'h47;
    // bank 3 byte addresses, read-only spans and access constants
    localparam logic [7:0] RSVD_LO = 8'hE0;
    localparam logic [7:0] RSVD_HI = 8'hE3;
    localparam logic [7:0] BYTE_PATTERN = 8'hE6;
    localparam logic [7:0] RO_TAIL_LO = 8'hE7;
    localparam logic [7:0] LOCKED_READ = 8'hFF;
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] LAST_BYTE = 8'hFF;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sga_req_t;

    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] rdata;
    } sga_rsp_t;
endpackage

// ### src/sga_guard.sv
// Behaviour
// [RL1] four banks of 64 bytes each
// [RL2] unprotected bits readable and writable serially
// [RL3] writes change the live configuration image
// [RL4] read lock returns FFH for banks 0-2
// [RL5] low write lock: ack, no update
// [RL6] global write lock: ack, no update anywhere
// [RL7] global lock overrides low write lock
// [RL8] pins not serial: refuse all access
// [RL9] bank 3 open unless globally locked
// [RL10] low write lock bit never serially writable
// [RL11] address code field never serially writable
// [RL12] writes touch RAM mirror only, not NVM
// [RL13] reset reloads mirror from NVM
// [RL14] six lock combinations give documented access
// [RL15] bank 3 user fields read-only under global lock
// [RL16] soft reset bit one triggers NVM reload
// [RL17] master control byte carries programmed code
// [RL18] write commits at the acknowledge edge
`timescale 1ns/1ps
module sga_guard #(
    parameter int ADDR_W = sga_pkg::ADDR_W,
    parameter int DEPTH = sga_pkg::MEM_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_pins_en,
    input wire logic req_valid,
    input wire sga_pkg::sga_req_t req,
    output sga_pkg::sga_rsp_t rsp,
    output logic [ADDR_W-1:0] nvm_addr,
    input wire logic [7:0] nvm_data,
    output logic loading,
    output logic [sga_pkg::CODE_W-1:0] ctrl_code,
    input wire logic [ADDR_W-1:0] cfg_rd_addr,
    output logic [7:0] cfg_rd_data
);
    typedef enum logic {SGA_LOAD, SGA_RUN} sga_state_t;

    sga_state_t state_r;
    logic [ADDR_W-1:0] load_cnt_r;
    logic [7:0] mem [0:DEPTH-1]; // RL1
    logic ack_r;
    logic [7:0] rdata_r;
    logic [7:0] cfg_rd_data_r;
    logic [ADDR_W-1:0] addr_q_r;
    logic read_lock;
    logic wlock_low;
    logic wlock_all;
    logic low_bank;
    logic take;
    logic wr_blocked;
    logic [7:0] wmask;
    logic [7:0] cur_byte;
    logic [7:0] merged;
    logic soft_rst;

    assign read_lock = mem[sga_pkg::BYTE_READ_LOCK][sga_pkg::BIT_READ_LOCK];
    assign wlock_low = mem[sga_pkg::BYTE_WRITE_LOCK][sga_pkg::BIT_WLOCK_LOW];
    assign wlock_all = mem[sga_pkg::BYTE_WRITE_LOCK][sga_pkg::BIT_WLOCK_ALL];
    assign ctrl_code = mem[sga_pkg::BYTE_WRITE_LOCK][sga_pkg::CODE_LSB +: sga_pkg::CODE_W]; // RL17
    assign low_bank = req.addr[ADDR_W-1 -: 2] != sga_pkg::BANK_USER;
    assign take = req_valid && serial_pins_en && state_r == SGA_RUN; // RL8
    assign wr_blocked = wlock_all || (low_bank && wlock_low); // RL5 RL6 RL7 RL14
    assign cur_byte = mem[req.addr];
    assign loading = state_r == SGA_LOAD;
    assign nvm_addr = load_cnt_r;

    // per-byte bits that a serial write may change
    always_comb
    begin
        wmask = sga_pkg::MASK_ALL; // RL2
        if (req.addr == sga_pkg::BYTE_OSC_SRST)
            wmask = sga_pkg::OSC_SRST_WR_MASK;
        else if (req.addr >= sga_pkg::RSVD_LO && req.addr <= sga_pkg::RSVD_HI)
            wmask = sga_pkg::MASK_NONE;
        else if (req.addr == sga_pkg::BYTE_READ_LOCK)
            wmask = sga_pkg::MASK_NONE;
        else if (req.addr >= sga_pkg::RO_TAIL_LO)
            wmask = sga_pkg::MASK_NONE; // RL9 RL10 RL11
    end

    assign merged = (cur_byte & ~wmask) | (req.data & wmask); // RL15
    assign soft_rst = take && req.wr && !wr_blocked
        && req.addr == sga_pkg::BYTE_OSC_SRST && req.data[sga_pkg::BIT_SOFT_RST];

    // reload sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= SGA_LOAD; // RL13
            load_cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                SGA_LOAD:
                begin
                    load_cnt_r <= load_cnt_r + 1'b1;
                    if (load_cnt_r == sga_pkg::LAST_BYTE)
                        state_r <= SGA_RUN;
                end
                SGA_RUN:
                begin
                    if (soft_rst)
                    begin
                        state_r <= SGA_LOAD; // RL16
                        load_cnt_r <= '0;
                    end
                end
                default:
                begin
                    state_r <= SGA_LOAD;
                    load_cnt_r <= '0;
                end
            endcase
        end
    end

    // mirror storage; NVM itself is only ever read
    always_ff @(posedge clk)
    begin
        if (state_r == SGA_LOAD)
            mem[load_cnt_r] <= nvm_data; // RL13
        else if (take && req.wr && !wr_blocked)
            mem[req.addr] <= merged; // RL3 RL12 RL18
    end

    // answer path
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_r <= 1'b0;
            rdata_r <= sga_pkg::LOCKED_READ;
            addr_q_r <= '0;
        end
        else
        begin
            ack_r <= take; // RL5 RL6
            if (take)
            begin
                addr_q_r <= req.addr;
                if (!req.wr)
                    rdata_r <= (read_lock && low_bank) ? sga_pkg::LOCKED_READ : cur_byte; // RL4
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cfg_rd_data_r <= '0;
        else
            cfg_rd_data_r <= mem[cfg_rd_addr];
    end

    assign rsp.ack = ack_r;
    assign rsp.rdata = rdata_r;
    assign cfg_rd_data = cfg_rd_data_r;

    // helpers for checks
    logic [7:0] mem_q;
    logic [7:0] prev_load_byte;
    assign mem_q = mem[addr_q_r];
    assign prev_load_byte = mem[load_cnt_r - 1'b1];
    logic [7:0] cfg_now;
    assign cfg_now = mem[cfg_rd_addr];

    locked_read_a: assert property (@(posedge clk) disable iff (rst) // RL4
        take && !req.wr && read_lock && low_bank |=> rsp.rdata == sga_pkg::LOCKED_READ)
        else $error("locked low bank read did not return all ones");

    low_wlock_a: assert property (@(posedge clk) disable iff (rst) // RL5
        take && req.wr && wlock_low && low_bank |=> rsp.ack && mem_q == $past(cur_byte))
        else $error("low-bank write lock failed to block or ack");

    all_wlock_a: assert property (@(posedge clk) disable iff (rst) // RL6
        take && req.wr && wlock_all |=> rsp.ack && mem_q == $past(cur_byte))
        else $error("global write lock failed to block or ack");

    refuse_pins_a: assert property (@(posedge clk) disable iff (rst) // RL8
        !serial_pins_en ##1 !serial_pins_en |-> !rsp.ack)
        else $error("access acknowledged while pins not serial");

    code_hold_a: assert property (@(posedge clk) disable iff (rst) // RL11
        take && req.wr |=> ctrl_code == $past(ctrl_code))
        else $error("address code changed by serial write");

    lock_bit_a: assert property (@(posedge clk) disable iff (rst) // RL10
        take && req.wr |=> wlock_low == $past(wlock_low))
        else $error("low write lock changed by serial write");

    write_commit_a: assert property (@(posedge clk) disable iff (rst) // RL18
        take && req.wr && !wr_blocked && !soft_rst
        |=> rsp.ack && mem_q == (($past(cur_byte) & ~$past(wmask)) | ($past(req.data) & $past(wmask))))
        else $error("unblocked write not committed at ack");

    reload_a: assert property (@(posedge clk) disable iff (rst) // RL13
        state_r == SGA_LOAD ##1 load_cnt_r != '0 |-> prev_load_byte == $past(nvm_data))
        else $error("mirror byte not reloaded from nvm");

    soft_rst_a: assert property (@(posedge clk) disable iff (rst) // RL16
        soft_rst |=> loading && load_cnt_r == '0)
        else $error("soft reset bit did not start reload");

    ack_follow_a: assert property (@(posedge clk) disable iff (rst) // RL5 RL6
        take
        |=> rsp.ack)
        else $error("accepted access not acknowledged");

    ack_idle_a: assert property (@(posedge clk) disable iff (rst) // RL8
        !take
        |=> !rsp.ack)
        else $error("acknowledge without accepted access");

    pins_off_a: assert property (@(posedge clk) disable iff (rst) // RL8
        !serial_pins_en
        |=> !rsp.ack)
        else $error("acknowledge while pins not serial");

    load_refuse_a: assert property (@(posedge clk) disable iff (rst) // RL13
        loading
        |=> !rsp.ack)
        else $error("acknowledge during reload");

    rdata_hold_a: assert property (@(posedge clk) disable iff (rst) // RL4
        !(take && !req.wr)
        |=> $stable(rsp.rdata))
        else $error("read data changed without accepted read");

    open_read_a: assert property (@(posedge clk) disable iff (rst) // RL2
        take && !req.wr && !(read_lock && low_bank)
        |=> rsp.rdata == $past(cur_byte))
        else $error("unlocked read did not return stored byte");

    user_read_a: assert property (@(posedge clk) disable iff (rst) // RL9
        take && !req.wr && !low_bank
        |=> rsp.rdata == $past(cur_byte))
        else $error("bank 3 read did not return stored byte");

    blocked_write_a: assert property (@(posedge clk) disable iff (rst) // RL14
        take && req.wr && wr_blocked
        |=> rsp.ack && mem_q == $past(cur_byte))
        else $error("blocked write changed mirror or lost ack");

    all_lock_user_a: assert property (@(posedge clk) disable iff (rst) // RL7
        take && req.wr && wlock_all && !low_bank
        |=> mem_q == $past(cur_byte))
        else $error("global lock did not block bank 3 write");

    user_write_a: assert property (@(posedge clk) disable iff (rst) // RL9 RL15
        take && req.wr && !wlock_all && !low_bank && req.addr < sga_pkg::RSVD_LO
        && req.addr != sga_pkg::BYTE_OSC_SRST |=> mem_q == $past(req.data))
        else $error("open bank 3 write not stored");

    low_open_write_a: assert property (@(posedge clk) disable iff (rst) // RL2 RL3
        take && req.wr && low_bank && !wlock_low && !wlock_all
        |=> mem_q == $past(req.data))
        else $error("open low bank write not stored");

    ro_tail_a: assert property (@(posedge clk) disable iff (rst) // RL10 RL11
        take && req.wr && req.addr >= sga_pkg::RO_TAIL_LO
        |=> mem_q == $past(cur_byte))
        else $error("read-only tail byte changed by write");

    rsvd_span_a: assert property (@(posedge clk) disable iff (rst) // RL9
        take && req.wr && req.addr >= sga_pkg::RSVD_LO && req.addr <= sga_pkg::RSVD_HI
        |=> mem_q == $past(cur_byte))
        else $error("reserved byte changed by write");

    read_lock_byte_a: assert property (@(posedge clk) disable iff (rst) // RL9
        take && req.wr && req.addr == sga_pkg::BYTE_READ_LOCK
        |=> mem_q == $past(cur_byte))
        else $error("read lock byte changed by write");

    osc_rsvd_a: assert property (@(posedge clk) disable iff (rst) // RL15
        take && req.wr && req.addr == sga_pkg::BYTE_OSC_SRST
        |=> ((mem_q ^ $past(cur_byte)) & ~sga_pkg::OSC_SRST_WR_MASK) == sga_pkg::MASK_NONE)
        else $error("reserved oscillator bits changed by write");

    blocked_no_reload_a: assert property (@(posedge clk) disable iff (rst) // RL6 RL16
        take && req.wr && wr_blocked
        |=> !loading)
        else $error("blocked write started a reload");

    load_step_a: assert property (@(posedge clk) disable iff (rst) // RL13
        state_r == SGA_LOAD && load_cnt_r != sga_pkg::LAST_BYTE
        |=> loading && nvm_addr == $past(nvm_addr) + 1'b1)
        else $error("reload address did not advance");

    load_end_a: assert property (@(posedge clk) disable iff (rst) // RL13
        state_r == SGA_LOAD && load_cnt_r == sga_pkg::LAST_BYTE
        |=> !loading)
        else $error("reload did not end after last byte");

    run_hold_a: assert property (@(posedge clk) disable iff (rst) // RL12
        !loading && !soft_rst
        |=> !loading && $stable(nvm_addr))
        else $error("nvm touched outside reload");

    lock_hold_a: assert property (@(posedge clk) disable iff (rst) // RL10
        !loading && !soft_rst
        |=> $stable(read_lock) && $stable(wlock_all))
        else $error("lock bits changed while running");

    reset_values_a: assert property (@(posedge clk) // RL13
        rst
        |=> !rsp.ack && loading && rsp.rdata == sga_pkg::LOCKED_READ && cfg_rd_data == '0)
        else $error("wrong outputs after reset");

    cfg_port_a: assert property (@(posedge clk) disable iff (rst) // RL3
        1'b1
        |=> cfg_rd_data == $past(cfg_now))
        else $error("fabric read port did not show mirror byte");
endmodule

// ### testbench/sga_nvm_model.sv
`timescale 1ns/1ps
module sga_nvm_model (
    input wire logic [7:0] nvm_addr,
    input wire logic [2:0] lock_mode,
    output logic [7:0] nvm_data
);
    // fixed image, serial writes never reach it
    always_comb
    begin
        nvm_data = nvm_addr ^ 8'h3C;
        if (nvm_addr == 8'hE5)
            nvm_data = {7'h00, lock_mode[2]};
        if (nvm_addr == 8'hE9)
            nvm_data = {lock_mode[1:0], 2'h0, 4'hA};
    end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, pins = 1, req_valid = 0, loading;
    sga_pkg::sga_req_t req = '0;
    sga_pkg::sga_rsp_t rsp;
    logic [7:0] nvm_addr, nvm_data, cfg_rd_data, cfg_rd_addr = 8'h00;
    logic [3:0] ctrl_code;
    logic [2:0] lock_mode = 3'h0;
    int errors = 0, check_count = 0, cycles = 0;
    int mem[256];
    int pts[6] = '{10, 150, 200, 207, 230, 233};
    bit [2:0] modes[6] = '{3'h0, 3'h4, 3'h2, 3'h3, 3'h6, 3'h5};
    always #10 clk = ~clk;
    sga_guard dut_u (.clk(clk), .rst(rst), .serial_pins_en(pins), .req_valid(req_valid),
        .req(req), .rsp(rsp), .nvm_addr(nvm_addr), .nvm_data(nvm_data), .loading(loading),
        .ctrl_code(ctrl_code), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data));
    sga_nvm_model nvm_u (.nvm_addr(nvm_addr), .lock_mode(lock_mode), .nvm_data(nvm_data));
    function automatic int nv(int a);
        if (a == 229) return lock_mode[2];
        if (a == 233) return {lock_mode[1:0], 6'h0A};
        return (a ^ 8'h3C) & 8'hFF;
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(string what, int exp, logic [7:0] seen);
        logic [7:0] e;
        e = exp[7:0];
        check_count++;
        if (seen !== e)
        begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, e, seen);
        end
    endtask
    task automatic wait_load();
        int i;
        for (i = 0; i < 400 && loading !== 1'b0; i++) @(posedge clk);
        #1 chk("loading", 0, {7'h0, loading});
        for (i = 0; i < 256; i++) mem[i] = nv(i);
    endtask
    task automatic access(bit wr, int a, int d, bit take);
        bit low, blk;
        low = a < 192;
        blk = mem[233][6] || (low && mem[233][7]);
        req = {wr, a[7:0], d[7:0]};
        req_valid = 1;
        @(posedge clk);
        #1 req_valid = 0;
        chk("ack", take, {7'h0, rsp.ack});
        if (take && !wr) chk("rdata", (low && mem[229][0]) ? 8'hFF : mem[a], rsp.rdata);
        if (take && wr && !blk)
        begin
            if (a == 207) mem[a] = (mem[a] & 8'hB8) | (d & 8'h47);
            else if (!(a >= 224 && (a <= 227 || a == 229 || a >= 231))) mem[a] = d & 8'hFF;
            if (a == 207 && d[6]) wait_load();
        end
        @(posedge clk);
        #1;
    endtask
    initial
    begin
        int m, k, a;
        void'($urandom(32'h84AB981F));
        for (m = 0; m < 6; m++)
        begin
            lock_mode = modes[m];
            rst = 1;
            repeat (16) @(posedge clk);
            #1 rst = 0;
            chk("rst rdata", 8'hFF, rsp.rdata);
            chk("rst cfg", 0, cfg_rd_data);
            chk("rst loading", 1, {7'h0, loading});
            access(1, 5, 8'h99, 0);
            wait_load();
            pins = 0;
            access(0, 3, 0, 0);
            access(1, 3, 0, 0);
            pins = 1;
            foreach (pts[k]) access(1, pts[k], 8'hA5, 1);
            foreach (pts[k]) access(0, pts[k], 0, 1);
            for (k = 0; k < 60; k++)
            begin
                a = $urandom_range(255);
                access($urandom_range(1), a, $urandom_range(255), 1);
            end
            for (a = 0; a < 256; a++)
            begin
                cfg_rd_addr = a[7:0];
                @(posedge clk);
                #1 chk("cfg", mem[a], cfg_rd_data);
            end
            chk("code", nv(233) & 8'h0F, {4'h0, ctrl_code});
            access(1, 207, 8'h40, 1);
            access(0, 10, 0, 1);
            $display("test mode %0d done", m);
        end
        stop_test();
    end
    // hang guard, counted as a mismatch
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            stop_test();
        end
    end
endmodule
